// *** core/rap_top.sv ***
// Reset handling, status pin muxing and alarm interrupts with an AHB-Lite register slave
//
// Contract
// - Low reset input returns all internal logic to a known state.
// - Reset forces every configuration register to its default value.
// - Clock outputs stay tristated while reset is asserted.
// - Interrupt select set makes the combined pin the interrupt output.
// - Interrupt mode shows unmasked sources only, level set by interrupt polarity.
// - Input-one select with interrupt select clear shows input-one absence or offset.
// - Default polarity: combined pin 0 when input one present, 1 on alarm.
// - Alarm polarity sets combined pin level in input-one alarm mode.
// - Neither function selected: combined pin is tristated.
// - Input-two select set makes second pin show input-two absence or offset.
// - Default polarity: second pin 0 when input two present, 1 on alarm.
// - Alarm polarity also inverts the second pin.
// - Input-two select clear tristates the second pin.
// - Absence enable: 00 off, 01 reserved, 10 slow monitor, 11 normal.
// - Offset enable 0 disables and 1 enables offset monitoring.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module rap_top #(
  parameter int unsigned NUM_INPUTS = rap_pkg::RAP_NUM_INPUTS  // Monitored clock inputs
) (
  input  wire logic                          core_clk,                       // Core clock
  input  wire logic                          rst_n,                          // Async reset, low
  input  wire logic                          hsel,                           // Slave select
  input  wire logic [31:0]                   haddr,                          // Byte address
  input  wire logic [1:0]                    htrans,                         // Transfer type
  input  wire logic                          hwrite,                         // Write not read
  input  wire logic [2:0]                    hsize,                          // Transfer size
  input  wire logic [rap_pkg::RAP_DATA_W-1:0] hwdata,                        // Write data
  input  wire logic                          hready,                         // Bus ready
  output logic                               hreadyout,                      // Slave ready
  output logic                               hresp,                          // Response
  output logic      [rap_pkg::RAP_DATA_W-1:0] hrdata,                        // Read data
  input  wire logic                          in1_signal_absent,              // Input one absent
  input  wire logic                          in1_slow_signal_absent,         // Input one slow
  input  wire logic                          in1_freq_offset_alarm,          // Input one offset
  input  wire logic                          in2_signal_absent,              // Input two absent
  input  wire logic                          in2_slow_signal_absent,         // Input two slow
  input  wire logic                          in2_freq_offset_alarm,          // Input two offset
  output logic                               irq_or_in1_invalid_pin_o,       // Combined pin level
  output logic                               irq_or_in1_invalid_pin_oe,      // Combined pin drive
  output logic                               in2_invalid_pin_o,              // Second pin level
  output logic                               in2_invalid_pin_oe,             // Second pin drive
  output logic                               irq,                            // Interrupt, high
  output logic                               clk_out_enable                  // Clock outputs on
);
  import rap_pkg::*;

  if (NUM_INPUTS != RAP_NUM_INPUTS) begin : g_check
    $error("rap_top serves exactly two clock inputs");
  end

  typedef struct packed {
    rap_phase_t             phase;
    logic [RAP_ADDR_W-1:0]  wr_addr;
    logic [RAP_DATA_W-1:0]  rdata;
    logic                   irq_output_select;
    logic                   irq_polarity;
    logic                   in1_alarm_output_select;
    logic                   in2_alarm_output_select;
    logic                   alarm_polarity;
    logic [1:0]             offset_monitor_enable;
    logic [1:0]             in1_absence_monitor_enable;
    logic [1:0]             in2_absence_monitor_enable;
    logic                   clk_enable;
    logic [3:0]             irq_sts;
    logic [3:0]             irq_mask;
    logic                   pin1_o;
    logic                   pin1_oe;
    logic                   pin2_o;
    logic                   pin2_oe;
    logic                   irq;
  } rap_state_t;

  localparam rap_state_t ST_RST = '{
    phase:                      RAP_PH_IDLE,
    wr_addr:                    '0,
    rdata:                      '0,
    irq_output_select:          RAP_SEL_RST,
    irq_polarity:               RAP_POL_RST,
    in1_alarm_output_select:    RAP_SEL_RST,
    in2_alarm_output_select:    RAP_SEL_RST,
    alarm_polarity:             RAP_POL_RST,
    offset_monitor_enable:      {2{RAP_OFS_EN_RST}},
    in1_absence_monitor_enable: RAP_ABS_EN_RST,
    in2_absence_monitor_enable: RAP_ABS_EN_RST,
    clk_enable:                 RAP_CLK_EN_RST,
    irq_sts:                    RAP_IRQ_STS_RST,
    irq_mask:                   RAP_IRQ_MASK_RST,
    pin1_o:                     1'b0,
    pin1_oe:                    1'b0,
    pin2_o:                     1'b0,
    pin2_oe:                    1'b0,
    irq:                        1'b0
  };

  rap_state_t r;
  rap_state_t n;

  // Per-input detector flags and qualified results
  logic [NUM_INPUTS-1:0] raw_absent;
  logic [NUM_INPUTS-1:0] raw_slow;
  logic [NUM_INPUTS-1:0] raw_offset;
  logic [NUM_INPUTS-1:0] absent_hit;
  logic [NUM_INPUTS-1:0] offset_hit;
  logic [NUM_INPUTS-1:0] alarm;
  logic [1:0]            abs_en [NUM_INPUTS];

  assign raw_absent = {in2_signal_absent, in1_signal_absent};
  assign raw_slow   = {in2_slow_signal_absent, in1_slow_signal_absent};
  assign raw_offset = {in2_freq_offset_alarm, in1_freq_offset_alarm};
  assign abs_en[0]  = r.in1_absence_monitor_enable;
  assign abs_en[1]  = r.in2_absence_monitor_enable;

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_mon
    rap_mon_if mon ();

    assign mon.signal_absent          = raw_absent[i];
    assign mon.slow_signal_absent     = raw_slow[i];
    assign mon.freq_offset_alarm      = raw_offset[i];
    assign mon.absence_monitor_enable = abs_en[i];
    assign mon.offset_monitor_enable  = r.offset_monitor_enable[i];
    assign absent_hit[i]              = mon.absent_hit;
    assign offset_hit[i]              = mon.offset_hit;
    assign alarm[i]                   = mon.alarm;

    rap_alarm_qual u_qual (
      .mon (mon.qual)
    );
  end

  // Bus decode in the address phase
  logic                  take;
  logic                  take_wr;
  logic [RAP_ADDR_W-1:0] a_addr;
  logic [RAP_DATA_W-1:0] ctrl_word;
  logic [3:0]            events;
  logic [3:0]            w1c;
  logic                  irq_active;

  assign take    = hsel & htrans[1] & hready;
  assign take_wr = take & hwrite;
  assign a_addr  = haddr[RAP_ADDR_W-1:0];
  assign events  = {offset_hit[1], absent_hit[1], offset_hit[0], absent_hit[0]};

  always_comb begin
    n          = r;
    w1c        = 4'h0;
    ctrl_word  = '0;
    irq_active = 1'b0;

    // Data phase of a write: apply hwdata
    if (r.phase == RAP_PH_WRITE) begin
      case (r.wr_addr)
        RAP_OFS_CTRL: begin
          n.irq_output_select          = hwdata[RAP_CTRL_IRQ_SEL];
          n.irq_polarity               = hwdata[RAP_CTRL_IRQ_POL];
          n.in1_alarm_output_select    = hwdata[RAP_CTRL_IN1_SEL];
          n.in2_alarm_output_select    = hwdata[RAP_CTRL_IN2_SEL];
          n.alarm_polarity             = hwdata[RAP_CTRL_ALM_POL];
          n.offset_monitor_enable[0]   = hwdata[RAP_CTRL_IN1_OFS];
          n.offset_monitor_enable[1]   = hwdata[RAP_CTRL_IN2_OFS];
          n.in1_absence_monitor_enable = hwdata[RAP_CTRL_IN1_ABS +: 2];
          n.in2_absence_monitor_enable = hwdata[RAP_CTRL_IN2_ABS +: 2];
          n.clk_enable                 = hwdata[RAP_CTRL_CLK_EN];
        end
        RAP_OFS_IRQ_STS:  w1c        = hwdata[3:0];
        RAP_OFS_IRQ_MASK: n.irq_mask = hwdata[3:0];
        default: ;
      endcase
    end

    // Sticky status: a new event wins over a same-cycle clear
    n.irq_sts = (r.irq_sts & ~w1c) | events;

    // Next phase
    if (take_wr) begin
      n.phase   = RAP_PH_WRITE;
      n.wr_addr = a_addr;
    end else begin
      n.phase   = RAP_PH_IDLE;
      n.wr_addr = r.wr_addr;
    end

    // Read data taken from post-write values so back-to-back access is coherent
    ctrl_word[RAP_CTRL_IRQ_SEL]      = n.irq_output_select;
    ctrl_word[RAP_CTRL_IRQ_POL]      = n.irq_polarity;
    ctrl_word[RAP_CTRL_IN1_SEL]      = n.in1_alarm_output_select;
    ctrl_word[RAP_CTRL_IN2_SEL]      = n.in2_alarm_output_select;
    ctrl_word[RAP_CTRL_ALM_POL]      = n.alarm_polarity;
    ctrl_word[RAP_CTRL_IN1_OFS]      = n.offset_monitor_enable[0];
    ctrl_word[RAP_CTRL_IN2_OFS]      = n.offset_monitor_enable[1];
    ctrl_word[RAP_CTRL_IN1_ABS +: 2] = n.in1_absence_monitor_enable;
    ctrl_word[RAP_CTRL_IN2_ABS +: 2] = n.in2_absence_monitor_enable;
    ctrl_word[RAP_CTRL_CLK_EN]       = n.clk_enable;

    if (take && !hwrite) begin
      case (a_addr)
        RAP_OFS_CTRL:     n.rdata = ctrl_word;
        RAP_OFS_STATUS:   n.rdata = {28'h0000000, events};
        RAP_OFS_IRQ_STS:  n.rdata = {28'h0000000, n.irq_sts};
        RAP_OFS_IRQ_MASK: n.rdata = {28'h0000000, n.irq_mask};
        default:          n.rdata = '0;
      endcase
    end else begin
      n.rdata = '0;
    end

    // Interrupt from unmasked sticky bits
    irq_active = |(r.irq_sts & ~r.irq_mask);
    n.irq      = irq_active;

    // Combined status pin; interrupt function takes precedence
    if (r.irq_output_select) begin
      n.pin1_o  = irq_active ^ r.irq_polarity;
      n.pin1_oe = 1'b1;
    end else if (r.in1_alarm_output_select) begin
      n.pin1_o  = alarm[0] ^ r.alarm_polarity;
      n.pin1_oe = 1'b1;
    end else begin
      n.pin1_o  = 1'b0;
      n.pin1_oe = 1'b0;
    end

    // Second status pin
    if (r.in2_alarm_output_select) begin
      n.pin2_o  = alarm[1] ^ r.alarm_polarity;
      n.pin2_oe = 1'b1;
    end else begin
      n.pin2_o  = 1'b0;
      n.pin2_oe = 1'b0;
    end
  end

  // Every state bit returns to its default under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= ST_RST;
    end else begin
      r <= n;
    end
  end

  assign hreadyout                 = 1'b1;
  assign hresp                     = RAP_HRESP_OKAY;
  assign hrdata                    = r.rdata;
  assign irq_or_in1_invalid_pin_o  = r.pin1_o;
  assign irq_or_in1_invalid_pin_oe = r.pin1_oe;
  assign in2_invalid_pin_o         = r.pin2_o;
  assign in2_invalid_pin_oe        = r.pin2_oe;
  assign irq                       = r.irq;
  assign clk_out_enable            = r.clk_enable & rst_n;

endmodule : rap_top

// *** inc/rap_pkg.sv ***
// Constants and types shared by the reset and alarm pin control block
package rap_pkg;

  // Bus geometry
  localparam int unsigned RAP_ADDR_W      = 8;
  localparam int unsigned RAP_DATA_W      = 32;
  localparam int unsigned RAP_NUM_INPUTS  = 2;

  // Register byte offsets
  localparam logic [7:0]  RAP_OFS_CTRL     = 8'h00;
  localparam logic [7:0]  RAP_OFS_STATUS   = 8'h04;
  localparam logic [7:0]  RAP_OFS_IRQ_STS  = 8'h08;
  localparam logic [7:0]  RAP_OFS_IRQ_MASK = 8'h0C;

  // Control register field positions
  localparam int unsigned RAP_CTRL_IRQ_SEL   = 0;
  localparam int unsigned RAP_CTRL_IRQ_POL   = 1;
  localparam int unsigned RAP_CTRL_IN1_SEL   = 2;
  localparam int unsigned RAP_CTRL_IN2_SEL   = 3;
  localparam int unsigned RAP_CTRL_ALM_POL   = 4;
  localparam int unsigned RAP_CTRL_IN1_OFS   = 5;
  localparam int unsigned RAP_CTRL_IN2_OFS   = 6;
  localparam int unsigned RAP_CTRL_IN1_ABS   = 8;
  localparam int unsigned RAP_CTRL_IN2_ABS   = 10;
  localparam int unsigned RAP_CTRL_CLK_EN    = 12;

  // Reset values
  localparam logic        RAP_SEL_RST        = 1'b0;
  localparam logic        RAP_POL_RST        = 1'b0;
  localparam logic        RAP_OFS_EN_RST     = 1'b1;
  localparam logic [1:0]  RAP_ABS_EN_RST     = 2'h3;
  localparam logic        RAP_CLK_EN_RST     = 1'b0;
  localparam logic [3:0]  RAP_IRQ_STS_RST    = 4'h0;
  localparam logic [3:0]  RAP_IRQ_MASK_RST   = 4'hF;

  // Signal-absent monitor modes
  localparam logic [1:0]  RAP_ABS_OFF        = 2'h0;
  localparam logic [1:0]  RAP_ABS_RSVD       = 2'h1;
  localparam logic [1:0]  RAP_ABS_SLOW       = 2'h2;
  localparam logic [1:0]  RAP_ABS_NORMAL     = 2'h3;

  // AHB response code
  localparam logic        RAP_HRESP_OKAY     = 1'b0;

  // Bus data-phase tracking
  typedef enum logic [1:0] {
    RAP_PH_IDLE  = 2'b01,
    RAP_PH_WRITE = 2'b10
  } rap_phase_t;

endpackage : rap_pkg

// *** inc/rap_mon_if.sv ***
// Bundle between the pin controller and one input's alarm qualifier
`timescale 1ns/10ps
interface rap_mon_if;
  logic       signal_absent;
  logic       slow_signal_absent;
  logic       freq_offset_alarm;
  logic [1:0] absence_monitor_enable;
  logic       offset_monitor_enable;
  logic       absent_hit;
  logic       offset_hit;
  logic       alarm;

  modport qual (
    input  signal_absent,
    input  slow_signal_absent,
    input  freq_offset_alarm,
    input  absence_monitor_enable,
    input  offset_monitor_enable,
    output absent_hit,
    output offset_hit,
    output alarm
  );

  modport ctl (
    output signal_absent,
    output slow_signal_absent,
    output freq_offset_alarm,
    output absence_monitor_enable,
    output offset_monitor_enable,
    input  absent_hit,
    input  offset_hit,
    input  alarm
  );
endinterface : rap_mon_if

// *** core/rap_alarm_qual.sv ***
// Qualifies one clock input's detector flags with its monitor enables
`timescale 1ns/10ps
module rap_alarm_qual (
  rap_mon_if.qual mon   // Detector flags in, qualified alarm out
);
  import rap_pkg::*;

  always_comb begin
    case (mon.absence_monitor_enable)
      RAP_ABS_OFF:    mon.absent_hit = 1'b0;
      RAP_ABS_RSVD:   mon.absent_hit = 1'b0;
      RAP_ABS_SLOW:   mon.absent_hit = mon.slow_signal_absent;
      RAP_ABS_NORMAL: mon.absent_hit = mon.signal_absent;
      default:        mon.absent_hit = 1'b0;
    endcase
  end

  assign mon.offset_hit = mon.offset_monitor_enable & mon.freq_offset_alarm;
  assign mon.alarm      = mon.absent_hit | mon.offset_hit;

endmodule : rap_alarm_qual

// *** bench/rap_top_properties.sv ***
// Port-level assertions for the pin controller
`timescale 1ns/10ps
module rap_top_props (
  input wire logic                           core_clk,   // Clock
  input wire logic                           rst_n,      // Reset
  input wire logic                           hsel,       // Select
  input wire logic [31:0]                    haddr,      // Address
  input wire logic [1:0]                     htrans,     // Transfer
  input wire logic                           hwrite,     // Write
  input wire logic [rap_pkg::RAP_DATA_W-1:0] hwdata,     // Write data
  input wire logic                           hready,     // Ready
  input wire logic                           in1_signal_absent,       // In1 absent
  input wire logic                           in1_slow_signal_absent,  // In1 slow
  input wire logic                           in1_freq_offset_alarm,   // In1 offset
  input wire logic                           in2_signal_absent,       // In2 absent
  input wire logic                           in2_slow_signal_absent,  // In2 slow
  input wire logic                           in2_freq_offset_alarm,   // In2 offset
  input wire logic                           irq_or_in1_invalid_pin_o,  // Pin1
  input wire logic                           irq_or_in1_invalid_pin_oe, // Pin1 drive
  input wire logic                           in2_invalid_pin_o,         // Pin2
  input wire logic                           in2_invalid_pin_oe,        // Pin2 drive
  input wire logic                           irq,            // Interrupt
  input wire logic                           clk_out_enable  // Clock on
);
  import rap_pkg::*;
  logic        wr_pend_r;
  logic [12:0] ctrl_r;
  logic        alm1;
  logic        alm2;
  // Shadow of the control word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      ctrl_r    <= 13'h0F60;
    end else begin
      wr_pend_r <= hsel & htrans[1] & hready & hwrite & (haddr[7:0] == RAP_OFS_CTRL);
      if (wr_pend_r) begin
        ctrl_r <= hwdata[12:0];
      end
    end
  end
  assign alm1 = ((ctrl_r[9:8] == RAP_ABS_NORMAL) & in1_signal_absent)
              | ((ctrl_r[9:8] == RAP_ABS_SLOW) & in1_slow_signal_absent)
              | (ctrl_r[5] & in1_freq_offset_alarm);
  assign alm2 = ((ctrl_r[11:10] == RAP_ABS_NORMAL) & in2_signal_absent)
              | ((ctrl_r[11:10] == RAP_ABS_SLOW) & in2_slow_signal_absent)
              | (ctrl_r[6] & in2_freq_offset_alarm);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_clk_off_reset: assert property (disable iff (1'b0) !rst_n |-> !clk_out_enable)
    else $error("clock outputs enabled in reset");
  a_reset_quiet: assert property ($rose(rst_n) |->
    !irq_or_in1_invalid_pin_oe && !in2_invalid_pin_oe && !irq && !clk_out_enable)
    else $error("outputs not quiet after reset");
  a_clk_cfg: assert property (clk_out_enable == ctrl_r[12])
    else $error("clock enable differs from control");
  a_pin1_idle: assert property ($stable(ctrl_r) && !ctrl_r[0] && !ctrl_r[2] |->
    !irq_or_in1_invalid_pin_oe) else $error("pin1 driven with no function");
  a_pin2_idle: assert property ($stable(ctrl_r) && !ctrl_r[3] |-> !in2_invalid_pin_oe)
    else $error("pin2 driven while deselected");
  a_pin1_alarm: assert property ($stable(ctrl_r) && ctrl_r[2] && !ctrl_r[0] |->
    irq_or_in1_invalid_pin_oe && irq_or_in1_invalid_pin_o == ($past(alm1) ^ ctrl_r[4]))
    else $error("pin1 alarm level wrong");
  a_pin2_alarm: assert property ($stable(ctrl_r) && ctrl_r[3] |->
    in2_invalid_pin_oe && in2_invalid_pin_o == ($past(alm2) ^ ctrl_r[4]))
    else $error("pin2 alarm level wrong");
  a_irq_pin: assert property ($stable(ctrl_r) && ctrl_r[0] |->
    irq_or_in1_invalid_pin_oe && irq_or_in1_invalid_pin_o == (irq ^ ctrl_r[1]))
    else $error("pin1 does not follow interrupt");
  c_irq_rise: cover property ($rose(irq));
  c_pin2_alarm: cover property (in2_invalid_pin_oe && in2_invalid_pin_o);
  c_clk_on: cover property ($rose(clk_out_enable));
endmodule : rap_top_props

bind rap_top rap_top_props u_props (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .in1_signal_absent, .in1_slow_signal_absent, .in1_freq_offset_alarm,
  .in2_signal_absent, .in2_slow_signal_absent, .in2_freq_offset_alarm,
  .irq_or_in1_invalid_pin_o, .irq_or_in1_invalid_pin_oe, .in2_invalid_pin_o,
  .in2_invalid_pin_oe, .irq, .clk_out_enable);

// *** bench/rap_host_model.sv ***
// Host-side view of the two status pins
`timescale 1ns/10ps
module rap_host_model (
  input  wire logic core_clk, // Clock
  input  wire logic pin1_o,   // Pin1 level
  input  wire logic pin1_oe,  // Pin1 drive
  input  wire logic pin2_o,   // Pin2 level
  input  wire logic pin2_oe,  // Pin2 drive
  output logic      pin1,     // Pin1 as seen
  output logic      pin2      // Pin2 as seen
);
  logic last1_r = 1'b0;
  logic last2_r = 1'b0;
  // No pull on the pins: a released pin reads opposite to its last driven level
  always @(posedge core_clk) begin
    if (pin1_oe) begin
      last1_r <= pin1_o;
    end
    if (pin2_oe) begin
      last2_r <= pin2_o;
    end
  end
  assign pin1 = pin1_oe ? pin1_o : ~last1_r;
  assign pin2 = pin2_oe ? pin2_o : ~last2_r;
endmodule : rap_host_model

// *** bench/rap_top_tb.sv ***
// Self-checking bench for the pin controller
`timescale 1ns/10ps
module rap_top_tb;
  import rap_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [5:0]  det      = 6'h0;
  logic        hready, hreadyout, hresp, p1_o, p1_oe, p2_o, p2_oe, irq, clk_out_enable;
  logic        pin1, pin2;
  logic [31:0] hrdata, rd;
  int          err_count   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  always #5 core_clk = ~core_clk;
  assign hready = hreadyout;
  rap_top DUT (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .in1_signal_absent(det[0]),
    .in1_slow_signal_absent(det[1]), .in1_freq_offset_alarm(det[2]),
    .in2_signal_absent(det[3]), .in2_slow_signal_absent(det[4]),
    .in2_freq_offset_alarm(det[5]), .irq_or_in1_invalid_pin_o(p1_o),
    .irq_or_in1_invalid_pin_oe(p1_oe), .in2_invalid_pin_o(p2_o),
    .in2_invalid_pin_oe(p2_oe), .irq, .clk_out_enable);
  rap_host_model HOST (.core_clk, .pin1_o(p1_o), .pin1_oe(p1_oe), .pin2_o(p2_o),
    .pin2_oe(p2_oe), .pin1, .pin2);
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic t_reset_vals;
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    bus(1'b0, RAP_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0000_0F60, rd);
    bus(1'b0, RAP_OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h0000_000F, rd);
    chk("pins oe", 32'h0, {30'h0, p1_oe, p2_oe});
    chk("clk en", 32'h0, {31'h0, clk_out_enable});
  endtask : t_reset_vals
  task automatic t_in2_modes;
    logic [31:0] c;
    logic        e;
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        for (int k = 0; k < 3; k++) begin
          c = 32'h8 | (32'(m) << RAP_CTRL_IN2_ABS) | (32'(p) << RAP_CTRL_ALM_POL)
            | (32'(m & 1) << RAP_CTRL_IN2_OFS);
          e = (k == 0) ? (m == 3) : (k == 1) ? (m == 2) : m[0];
          bus(1'b1, RAP_OFS_CTRL, c);
          det <= 6'(8 << k);
          tick(4);
          chk("pin2", {30'h0, 1'b1, e ^ p[0]}, {30'h0, p2_oe, pin2});
        end
      end
    end
  endtask : t_in2_modes
  task automatic t_in1_alarm;
    for (int p = 0; p < 2; p++) begin
      det <= 6'h1;
      bus(1'b1, RAP_OFS_CTRL, 32'h304 | (32'(p) << RAP_CTRL_ALM_POL));
      tick(4);
      chk("pin1 bad", {30'h0, 1'b1, ~p[0]}, {30'h0, p1_oe, pin1});
      det <= 6'h0;
      tick(3);
      chk("pin1 ok", {30'h0, 1'b1, p[0]}, {30'h0, p1_oe, pin1});
    end
    bus(1'b1, RAP_OFS_CTRL, 32'h224);
    for (int k = 0; k < 3; k++) begin
      det <= 6'(1 << k);
      tick(4);
      chk("pin1 slow", {30'h0, 1'b1, k != 0}, {30'h0, p1_oe, pin1});
      bus(1'b0, RAP_OFS_STATUS, 32'h0);
      chk("status", (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : 32'h2, rd);
    end
    bus(1'b1, RAP_OFS_CTRL, 32'h0);
    tick(4);
    chk("idle", 32'h0, {28'h0, p1_oe, p2_oe, p1_o, p2_o});
  endtask : t_in1_alarm
  task automatic t_irq;
    det <= 6'h0;
    bus(1'b1, RAP_OFS_IRQ_STS, 32'hF);
    bus(1'b1, RAP_OFS_IRQ_MASK, 32'hE);
    bus(1'b1, RAP_OFS_CTRL, 32'hF05);
    tick(4);
    chk("irq idle", 32'h0, {31'h0, irq});
    det <= 6'h9;
    tick(4);
    chk("irq on", 32'h7, {29'h0, irq, p1_oe, pin1});
    bus(1'b1, RAP_OFS_CTRL, 32'hF07);
    tick(4);
    chk("irq inv", 32'h6, {29'h0, irq, p1_oe, pin1});
    det <= 6'h8;
    bus(1'b1, RAP_OFS_IRQ_STS, 32'h1);
    tick(4);
    chk("irq clr", 32'h3, {29'h0, irq, p1_oe, pin1});
    bus(1'b0, RAP_OFS_IRQ_STS, 32'h0);
    chk("sticky", 32'h4, rd);
    bus(1'b1, RAP_OFS_IRQ_STS, 32'h4);
    bus(1'b0, RAP_OFS_IRQ_STS, 32'h0);
    chk("set wins", 32'h4, rd);
    det <= 6'h0;
    bus(1'b1, RAP_OFS_IRQ_STS, 32'h4);
    bus(1'b0, RAP_OFS_IRQ_STS, 32'h0);
    chk("cleared", 32'h0, rd);
  endtask : t_irq
  task automatic t_clk_reset;
    bus(1'b1, RAP_OFS_CTRL, 32'h1000);
    tick(2);
    chk("clk on", 32'h1, {31'h0, clk_out_enable});
    rst_n <= 1'b0;
    tick(1);
    chk("clk rst", 32'h0, {29'h0, clk_out_enable, p1_oe, p2_oe});
    tick(2);
    rst_n <= 1'b1;
    bus(1'b0, RAP_OFS_CTRL, 32'h0);
    chk("ctrl rst", 32'h0000_0F60, rd);
  endtask : t_clk_reset
  initial begin
    tick(12);
    rst_n <= 1'b1;
    t_reset_vals();
    t_in2_modes();
    t_in1_alarm();
    t_irq();
    t_clk_reset();
    end_sim();
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
endmodule : rap_top_tb
